// file: rtl/ppm_pkg.sv
// ppm_pkg: register map, field layout, modes and timing for the
// pulse/period measurement block.
// assumes a 250 MHz sys_clk and a 32-bit avalon-mm register bus.
package ppm_pkg;
  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_TBSEL = 6'h04;
  localparam logic [5:0] OFS_LIMIT = 6'h08;
  localparam logic [5:0] OFS_STATUS = 6'h0c;
  localparam logic [5:0] OFS_COUNT = 6'h10;
  localparam logic [5:0] OFS_IRQ_STAT = 6'h14;
  localparam logic [5:0] OFS_IRQ_CLR = 6'h18;
  localparam logic [5:0] OFS_IRQ_EN = 6'h1c;
  // ---------------------------------------------------------------
  // control fields
  // ---------------------------------------------------------------
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_CASCADE_BIT = 1;
  localparam int CTRL_TYPE_LSB = 4;
  localparam logic [1:0] TYPE_RESET = 2'h2;
  localparam logic [31:0] TBSEL_RESET = 32'h0000_0000;
  localparam logic [31:0] TBSEL_INTERNAL = 32'h0098_9680;
  localparam logic [31:0] LIMIT_DEFAULT = 32'hffff_ffff;
  // ---------------------------------------------------------------
  // status fields and event bits
  // ---------------------------------------------------------------
  localparam int ST_BUSY = 0;
  localparam int ST_VALID = 1;
  localparam int ST_OVERFLOW = 2;
  localparam int ST_TIMEOUT = 3;
  localparam int ST_DONE = 4;
  localparam int NUM_EVT = 3;
  localparam int EVT_DONE = 0;
  localparam int EVT_OVERFLOW = 1;
  localparam int EVT_TIMEOUT = 2;
  // ---------------------------------------------------------------
  // counting limits and timing
  // ---------------------------------------------------------------
  localparam logic [31:0] MIN_VALID_COUNT = 32'h0000_0005;
  localparam logic [31:0] CASCADE_WEIGHT = 32'h0001_0000;
  localparam int LIMIT_RANGES = 4;
  localparam logic [31:0] LIMIT_TB_CYCLES = 32'h0004_0000;
  localparam int DEFAULT_LIMIT_S = 5;
  localparam longint CLK_HZ = 250000000;
  localparam longint DEFAULT_LIMIT_CYC = DEFAULT_LIMIT_S * CLK_HZ;
  // measurement type
  typedef enum logic [1:0] {
    MT_HIGH = 2'b00,
    MT_LOW = 2'b01,
    MT_RISE = 2'b10,
    MT_FALL = 2'b11
  } ppm_type_t;
  typedef enum logic [1:0] {
    PS_IDLE = 2'b00,
    PS_ARM = 2'b01,
    PS_COUNT = 2'b10,
    PS_DONE = 2'b11
  } ppm_state_t;
endpackage : ppm_pkg

// file: rtl/ppm_evt_if.sv
// ppm_evt_if: event pulses from the measurement core to the
// interrupt collector.
// assumes one clock domain.
`timescale 1ns/1ns
interface ppm_evt_if;
  logic [ppm_pkg::NUM_EVT-1:0] evt;
  logic [ppm_pkg::NUM_EVT-1:0] clr;
  logic [ppm_pkg::NUM_EVT-1:0] en;
  logic [ppm_pkg::NUM_EVT-1:0] stat;
  logic irq;
  modport src (output evt, output clr, output en, input stat, input irq);
  modport sink (input evt, input clr, input en, output stat, output irq);
endinterface : ppm_evt_if

// file: rtl/ppm_irq.sv
// ppm_irq: sticky event bits, enable gating, one level interrupt.
// assumes evt and clr are one-cycle pulses on sys_clk.
`timescale 1ns/1ns
module ppm_irq (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // events
  ppm_evt_if.sink ev
);
  // ---------------------------------------------------------------
  // sticky bits
  // ---------------------------------------------------------------
  logic [ppm_pkg::NUM_EVT-1:0] stat_q;
  for (genvar i = 0; i < ppm_pkg::NUM_EVT; i++) begin : g_bit
    always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
        stat_q[i] <= 1'b0;
      end else if (ev.evt[i]) begin
        // set beats a clear in the same cycle
        stat_q[i] <= 1'b1;
      end else if (ev.clr[i]) begin
        stat_q[i] <= 1'b0;
      end
    end
  end
  assign ev.stat = stat_q;
  assign ev.irq = |(stat_q & ev.en);
endmodule : ppm_irq

// file: rtl/ppm_measure.sv
// ppm_measure: pulse-width and period measurement counter with an
// avalon-mm register slave and a level interrupt.
// assumes gate and timebase inputs are synchronous to sys_clk.
//
// What this block does
// - type 0 high width, 1 low width
// - type 2 rise period, 3 fall; default 2
// - count timebase ticks only while gated
// - timebase 0 or 10000000 selects internal tick
// - duration is count over timebase, always reported; the block reports only the raw count
// - cascaded count is upper shifted 16 plus lower
// - overflow at terminal count is a flag only
// - valid only without overflow or too-small count
// - limit -1 means five seconds or four ranges
// - no valid reading in time sets timeout flag; here only a wait limit that runs out before the stop edge does
// - count reads the live counter value
//
// Our own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
module ppm_measure #(
  parameter longint LIMIT_CYC = ppm_pkg::DEFAULT_LIMIT_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // measured signal and external timebase
  input wire logic measured_gate_input,
  input wire logic ext_timebase,
  // status outputs
  output logic counter_output_pin,
  output logic irq
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic start_q;
  logic cascade_q;
  ppm_pkg::ppm_type_t type_q;
  logic [31:0] tbsel_q;
  logic [31:0] limit_q;
  logic [2:0] en_q;
  logic [31:0] rdata_q;
  logic rvalid_q;
  ppm_pkg::ppm_state_t state_q;
  logic [31:0] count_q;
  logic valid_q;
  logic ovf_q;
  logic tmo_q;
  logic gate_q;
  logic ext_q;
  logic [39:0] wait_q;
  logic [2:0] evt_d;
  logic [2:0] clr_d;
  ppm_evt_if ev ();

  // ---------------------------------------------------------------
  // bus: writes take one cycle, reads answer one cycle later
  // ---------------------------------------------------------------
  logic wr_ctrl;
  assign wr_ctrl = avs_write && avs_address == ppm_pkg::OFS_CTRL &&
                   avs_byteenable[0];
  assign avs_waitrequest = avs_read && !rvalid_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      start_q <= 1'b0;
      cascade_q <= 1'b0;
      type_q <= ppm_pkg::ppm_type_t'(ppm_pkg::TYPE_RESET);
      tbsel_q <= ppm_pkg::TBSEL_RESET;
      limit_q <= ppm_pkg::LIMIT_DEFAULT;
      en_q <= 3'h0;
    end else begin
      start_q <= wr_ctrl && avs_writedata[ppm_pkg::CTRL_START_BIT];
      if (wr_ctrl) begin
        cascade_q <= avs_writedata[ppm_pkg::CTRL_CASCADE_BIT];
        type_q <= ppm_pkg::ppm_type_t'(
          avs_writedata[ppm_pkg::CTRL_TYPE_LSB +: 2]);
      end
      if (avs_write && avs_address == ppm_pkg::OFS_TBSEL) begin
        tbsel_q <= avs_writedata;
      end
      if (avs_write && avs_address == ppm_pkg::OFS_LIMIT) begin
        limit_q <= avs_writedata;
      end
      if (avs_write && avs_address == ppm_pkg::OFS_IRQ_EN) begin
        en_q <= avs_writedata[2:0];
      end
    end
  end

  assign clr_d = (avs_write && avs_address == ppm_pkg::OFS_IRQ_CLR) ?
                 avs_writedata[2:0] : 3'h0;

  // ---------------------------------------------------------------
  // timebase tick and gate edges
  // ---------------------------------------------------------------
  logic int_tb;
  logic tick;
  logic rise;
  logic fall;
  logic gate_on;
  logic start_edge;
  logic stop_edge;
  // only the two documented settings mean internal
  assign int_tb = tbsel_q == 32'h0 ||
                  tbsel_q == ppm_pkg::TBSEL_INTERNAL;
  assign tick = int_tb ? 1'b1 : (ext_timebase && !ext_q);
  assign rise = measured_gate_input && !gate_q;
  assign fall = !measured_gate_input && gate_q;

  always_comb begin
    unique case (type_q)
      ppm_pkg::MT_HIGH: begin
        start_edge = rise;
        stop_edge = fall;
      end
      ppm_pkg::MT_LOW: begin
        start_edge = fall;
        stop_edge = rise;
      end
      ppm_pkg::MT_RISE: begin
        start_edge = rise;
        stop_edge = rise;
      end
      ppm_pkg::MT_FALL: begin
        start_edge = fall;
        stop_edge = fall;
      end
    endcase
  end
  // the window itself gates counting between its two edges
  assign gate_on = state_q == ppm_pkg::PS_COUNT;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      gate_q <= 1'b0;
      ext_q <= 1'b0;
    end else begin
      gate_q <= measured_gate_input;
      ext_q <= ext_timebase;
    end
  end

  // ---------------------------------------------------------------
  // measurement sequence
  // ---------------------------------------------------------------
  logic [31:0] term;
  logic at_term;
  logic wait_hit;
  logic [39:0] wait_lim;
  logic [39:0] tb_lim;
  logic [39:0] dflt_lim;
  // 16-bit range alone, or two counters cascaded to 32 bits
  assign term = cascade_q ? 32'hffff_ffff :
                (ppm_pkg::CASCADE_WEIGHT - 32'h1);
  assign at_term = count_q == term;
  // four ranges in timebase ticks, capped by five seconds
  assign tb_lim = {8'h0, ppm_pkg::LIMIT_TB_CYCLES};
  assign dflt_lim = 40'(LIMIT_CYC);
  assign wait_lim = (limit_q == ppm_pkg::LIMIT_DEFAULT) ?
                    (tb_lim > dflt_lim ? dflt_lim : tb_lim) :
                    {8'h0, limit_q};
  assign wait_hit = wait_q >= wait_lim;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= ppm_pkg::PS_IDLE;
    end else if (start_q) begin
      state_q <= ppm_pkg::PS_ARM;
    end else begin
      unique case (state_q)
        ppm_pkg::PS_IDLE: state_q <= ppm_pkg::PS_IDLE;
        ppm_pkg::PS_ARM: begin
          if (wait_hit) state_q <= ppm_pkg::PS_DONE;
          else if (start_edge) state_q <= ppm_pkg::PS_COUNT;
        end
        ppm_pkg::PS_COUNT: begin
          if (stop_edge || wait_hit) begin
            state_q <= ppm_pkg::PS_DONE;
          end
        end
        ppm_pkg::PS_DONE: state_q <= ppm_pkg::PS_DONE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // counter, flags and wait timer
  // ---------------------------------------------------------------
  logic finish;
  assign finish = state_q != ppm_pkg::PS_DONE &&
                  state_q != ppm_pkg::PS_IDLE && !start_q &&
                  ((state_q == ppm_pkg::PS_COUNT && stop_edge) ||
                   wait_hit);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      count_q <= 32'h0;
      ovf_q <= 1'b0;
    end else if (start_q) begin
      count_q <= 32'h0;
      ovf_q <= 1'b0;
    end else if (gate_on && tick && !stop_edge) begin
      // saturate at terminal count instead of wrapping
      if (at_term) begin
        ovf_q <= 1'b1;
      end else begin
        count_q <= count_q + 32'h1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wait_q <= 40'h0;
    end else if (start_q) begin
      wait_q <= 40'h0;
    end else if (state_q == ppm_pkg::PS_ARM ||
                 state_q == ppm_pkg::PS_COUNT) begin
      // external timebase only advances the wait on its ticks
      if (tick) wait_q <= wait_q + 40'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      valid_q <= 1'b0;
      tmo_q <= 1'b0;
    end else if (start_q) begin
      valid_q <= 1'b0;
      tmo_q <= 1'b0;
    end else if (finish) begin
      // too few counts is an underflow, not a reading
      valid_q <= !wait_hit && !ovf_q &&
                 count_q >= ppm_pkg::MIN_VALID_COUNT;
      tmo_q <= wait_hit;
    end
  end

  // ---------------------------------------------------------------
  // interrupts
  // ---------------------------------------------------------------
  assign evt_d[ppm_pkg::EVT_DONE] = finish;
  // same qualifiers as the flag, so event and flag never disagree
  assign evt_d[ppm_pkg::EVT_OVERFLOW] = gate_on && tick && at_term &&
                                        !stop_edge && !ovf_q &&
                                        !start_q;
  assign evt_d[ppm_pkg::EVT_TIMEOUT] = finish && wait_hit;
  assign ev.evt = evt_d;
  assign ev.clr = clr_d;
  assign ev.en = en_q;

  ppm_irq u_irq (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .ev(ev)
  );
  assign irq = ev.irq;

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  logic [31:0] rmux;
  always_comb begin
    rmux = 32'h0;
    unique case (avs_address)
      ppm_pkg::OFS_CTRL: begin
        rmux[ppm_pkg::CTRL_CASCADE_BIT] = cascade_q;
        rmux[ppm_pkg::CTRL_TYPE_LSB +: 2] = type_q;
      end
      ppm_pkg::OFS_TBSEL: rmux = tbsel_q;
      ppm_pkg::OFS_LIMIT: rmux = limit_q;
      ppm_pkg::OFS_STATUS: begin
        rmux[ppm_pkg::ST_BUSY] = state_q == ppm_pkg::PS_ARM ||
                                 state_q == ppm_pkg::PS_COUNT;
        rmux[ppm_pkg::ST_VALID] = valid_q;
        rmux[ppm_pkg::ST_OVERFLOW] = ovf_q;
        rmux[ppm_pkg::ST_TIMEOUT] = tmo_q;
        rmux[ppm_pkg::ST_DONE] = state_q == ppm_pkg::PS_DONE;
      end
      // live value, readable whether valid or not
      ppm_pkg::OFS_COUNT: rmux = count_q;
      ppm_pkg::OFS_IRQ_STAT: rmux[2:0] = ev.stat;
      ppm_pkg::OFS_IRQ_EN: rmux[2:0] = en_q;
      default: rmux = 32'h0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdata_q <= 32'h0;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= avs_read && !rvalid_q;
      // capture once per read so the answer stands until the next one
      if (avs_read && !rvalid_q) rdata_q <= rmux;
    end
  end
  assign avs_readdata = rdata_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      counter_output_pin <= 1'b0;
    end else begin
      counter_output_pin <= gate_on;
    end
  end
endmodule : ppm_measure

// file: tb/ppm_measure_chk.sv
// ppm_measure_chk: port-level checks of the measurement block.
// assumes it is bound onto every ppm_measure instance.
`timescale 1ns/1ns
module ppm_chk (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // bus
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // pins
  input wire logic measured_gate_input,
  input wire logic counter_output_pin,
  input wire logic irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // gate history, covers sync and edge-detect latency
  logic [4:0] hist_q;
  always_ff @(posedge sys_clk) begin
    hist_q <= {hist_q[3:0], measured_gate_input};
  end
  a_write_no_wait: assert property (avs_write |-> !avs_waitrequest)
    else $error("write stalled");
  a_read_first_wait: assert property ($rose(avs_read) |-> avs_waitrequest)
    else $error("read answered too early");
  a_read_one_wait: assert property (avs_read && avs_waitrequest
    |=> !avs_waitrequest) else $error("read wait too long");
  a_idle_no_wait: assert property (!avs_read |-> !avs_waitrequest)
    else $error("wait without read");
  a_data_holds: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved between reads");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest &&
    avs_address > 6'h1f |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_clr_reads_zero: assert property (avs_read && !avs_waitrequest &&
    avs_address == 6'h18 |-> avs_readdata == 32'h0)
    else $error("clear register read not zero");
  a_reset_quiet: assert property ($rose(rst_n) |->
    !irq && !counter_output_pin && avs_readdata == 32'h0)
    else $error("outputs busy after reset");
  a_window_on_edge: assert property ($rose(counter_output_pin) |->
    {hist_q, measured_gate_input} != 6'h00 &&
    {hist_q, measured_gate_input} != 6'h3f)
    else $error("window opened without gate edge");
endmodule : ppm_chk
bind ppm_measure ppm_chk u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .measured_gate_input(measured_gate_input),
  .counter_output_pin(counter_output_pin), .irq(irq));

// file: tb/ppm_gate_src.sv
// ppm_gate_src: square-wave gate source and free-running timebase.
// assumes hi and lo stay steady while run is high.
`timescale 1ns/1ns
module ppm_gate_src (
  // clock and control
  input wire logic sys_clk,
  input wire logic run,
  input wire logic [31:0] hi,
  input wire logic [31:0] lo,
  // pins
  output logic measured_gate_input,
  output logic ext_timebase
);
  logic [31:0] n_q;
  initial begin
    measured_gate_input = 1'b0;
    ext_timebase = 1'b0;
    n_q = 32'h0;
  end
  // low phase first so each run starts from a known edge
  always @(posedge sys_clk) begin
    ext_timebase <= !ext_timebase;
    if (!run) begin
      measured_gate_input <= 1'b0;
      n_q <= 32'h0;
    end else if (n_q + 1 >= (measured_gate_input ? hi : lo)) begin
      measured_gate_input <= !measured_gate_input;
      n_q <= 32'h0;
    end else begin
      n_q <= n_q + 1;
    end
  end
endmodule : ppm_gate_src

// file: tb/ppm_measure_tb.sv
// ppm_measure_tb: random and corner-case measurements over the bus.
// assumes ppm_measure with a shortened wait limit.
`timescale 1ns/1ns
module ppm_measure_tb;
  localparam longint LIM = 1000;
  logic sys_clk, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, hi, lo, d, e, tb;
  logic [3:0] avs_byteenable;
  logic measured_gate_input, ext_timebase, counter_output_pin, irq, run;
  int n_mismatch, num_checks, seed, k, cyc, t0;
  logic [5:0] ra [0:6] = '{6'h04, 6'h08, 6'h1c, 6'h10, 6'h18, 6'h20,
    6'h3c};
  logic [31:0] rv [0:6] = '{32'h0, 32'hffffffff, 32'h0, 32'h0, 32'h0,
    32'h0, 32'h0};
  ppm_measure #(.LIMIT_CYC(LIM)) DUT (.sys_clk(sys_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .measured_gate_input(measured_gate_input),
    .ext_timebase(ext_timebase),
    .counter_output_pin(counter_output_pin), .irq(irq));
  ppm_gate_src src (.sys_clk(sys_clk), .run(run), .hi(hi), .lo(lo),
    .measured_gate_input(measured_gate_input),
    .ext_timebase(ext_timebase));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) cyc <= cyc + 1;
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up
  task chk(input string nm, input logic [31:0] s, input logic [31:0] x,
    input int tol);
    num_checks++;
    if ((s ^ s) !== 32'h0 || s + tol < x || s > x + tol) begin
      n_mismatch++;
      $display("unexpected %s expected %0h seen %0h", nm, x, s);
    end
  endtask : chk
  // one avalon cycle; read data lands in d
  task bus(input logic wr, input logic [5:0] a, input logic [31:0] wd);
    int i;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_read <= !wr;
    avs_write <= wr;
    for (i = 0; i < 50; i++) begin
      @(posedge sys_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 50) begin
      n_mismatch++;
      wrap_up();
    end
    d = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task wstat(input int b, input int n);
    int i;
    for (i = 0; i < n; i++) begin
      bus(1'b0, ppm_pkg::OFS_STATUS, 32'h0);
      if (d[b] === 1'b1) break;
    end
    if (i == n) begin
      n_mismatch++;
      wrap_up();
    end
  endtask : wstat
  task start(input logic [1:0] t, input logic c);
    bus(1'b1, ppm_pkg::OFS_CTRL, {26'h0, t, 2'h0, c, 1'b1});
  endtask : start
  function automatic logic [31:0] expc(input logic [1:0] t,
    input logic [31:0] h, input logic [31:0] l);
    case (t)
      2'h0: expc = h;
      2'h1: expc = l;
      default: expc = h + l;
    endcase
  endfunction : expc
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    seed = 66882;
    n_mismatch = 0;
    num_checks = 0;
    cyc = 0;
    rst_n = 1'b0;
    avs_address = 6'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    run = 1'b0;
    hi = 32'h8;
    lo = 32'h8;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    bus(1'b0, ppm_pkg::OFS_CTRL, 32'h0);
    chk("type", 32'(d[5:4]), 32'(ppm_pkg::TYPE_RESET), 0);
    bus(1'b1, 6'h24, 32'hffffffff);
    for (k = 0; k < 7; k++) begin
      bus(1'b0, ra[k], 32'h0);
      chk("reset value", d, rv[k], 0);
    end
    // random widths, every type, internal and external timebase
    for (k = 0; k < 8; k++) begin
      hi <= 32'(8 + 2 * ($random(seed) & 15));
      lo <= 32'(8 + 2 * ($random(seed) & 15));
      tb = (k < 4) ? (k[0] ? ppm_pkg::TBSEL_INTERNAL : 32'h0) : 32'h3e8;
      bus(1'b1, ppm_pkg::OFS_TBSEL, tb);
      run <= 1'b0;
      start(k[1:0], k[0]);
      run <= 1'b1;
      wstat(ppm_pkg::ST_DONE, 600);
      bus(1'b0, ppm_pkg::OFS_COUNT, 32'h0);
      e = expc(k[1:0], hi, lo) / ((k < 4) ? 1 : 2);
      chk("count", d, e, (k < 4) ? 1 : 2);
      bus(1'b0, ppm_pkg::OFS_STATUS, 32'h0);
      chk("valid", 32'(d[ppm_pkg::ST_VALID]), 32'h1, 0);
    end
    // too few ticks: reading must be invalid, done stays masked
    bus(1'b1, ppm_pkg::OFS_TBSEL, 32'h0);
    hi <= 32'h2;
    run <= 1'b0;
    start(2'h0, 1'b0);
    run <= 1'b1;
    wstat(ppm_pkg::ST_DONE, 600);
    chk("small valid", 32'(d[ppm_pkg::ST_VALID]), 32'h0, 0);
    chk("masked irq", 32'(irq), 32'h0, 0);
    bus(1'b1, ppm_pkg::OFS_IRQ_EN, 32'h7);
    @(negedge sys_clk);
    chk("enabled irq", 32'(irq), 32'h1, 0);
    bus(1'b1, ppm_pkg::OFS_IRQ_CLR, 32'h7);
    @(negedge sys_clk);
    chk("cleared irq", 32'(irq), 32'h0, 0);
    // no gate edges at all: default wait limit runs out
    run <= 1'b0;
    t0 = cyc;
    start(2'h2, 1'b0);
    wstat(ppm_pkg::ST_TIMEOUT, 600);
    chk("wait limit", 32'(cyc - t0), 32'(LIM), 12);
    chk("timeout valid", 32'(d[ppm_pkg::ST_VALID]), 32'h0, 0);
    bus(1'b0, ppm_pkg::OFS_IRQ_STAT, 32'h0);
    chk("timeout event", 32'(d[2]), 32'h1, 0);
    chk("timeout irq", 32'(irq), 32'h1, 0);
    // long high pulse past terminal count, live reads on the way
    bus(1'b1, ppm_pkg::OFS_LIMIT, 32'h0002_0000);
    hi <= 32'd65540;
    lo <= 32'h4;
    start(2'h0, 1'b0);
    run <= 1'b1;
    repeat (20) bus(1'b0, ppm_pkg::OFS_COUNT, 32'h0);
    e = d;
    bus(1'b0, ppm_pkg::OFS_COUNT, 32'h0);
    chk("live count", 32'(d > e), 32'h1, 0);
    chk("window pin", 32'(counter_output_pin), 32'h1, 0);
    wstat(ppm_pkg::ST_DONE, 30000);
    chk("ovf flag", 32'(d[ppm_pkg::ST_OVERFLOW]), 32'h1, 0);
    chk("ovf valid", 32'(d[ppm_pkg::ST_VALID]), 32'h0, 0);
    bus(1'b0, ppm_pkg::OFS_COUNT, 32'h0);
    chk("terminal count", d, 32'h0000_ffff, 0);
    chk("window closed", 32'(counter_output_pin), 32'h0, 0);
    wrap_up();
  end
endmodule : ppm_measure_tb
